// >>> bench/dllcm_asserts.sv
// Port checker for the clock manager model
`timescale 1ns/100ps
module dllcm_asserts #(
   parameter bit         HOLD_UNTIL_LOCK = 1'b0,
   parameter logic [2:0] LOOP_INDEX      = 3'h0
) (
   // Clock and inputs
   input wire logic                          clk,
   input wire logic                          reset,
   input wire logic                          startup_request,
   // Outputs watched
   input wire logic                          config_done,
   input wire dllcm_pkg::dllcm_clocks_type   clocks,
   input wire logic                          locked,
   input wire logic                          drift_exceeded,
   input wire logic [dllcm_pkg::NETWORKS-1:0] network_reach
);
   import dllcm_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   // ----------------------------------------------------------------
   // Steps
   // ----------------------------------------------------------------
   sequence s_rel; $fell(reset); endsequence
   sequence s_zrise; locked && $rose(clocks.zero_phase_clock_out); endsequence
   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   property p_rel; s_rel |-> !locked && !config_done; endproperty
   a_rel: assert property (p_rel) else $error("lock or done high after reset");
   property p_hold; HOLD_UNTIL_LOCK && !locked |-> !config_done; endproperty
   a_hold: assert property (p_hold) else $error("done before lock");
   property p_cfg; !HOLD_UNTIL_LOCK && !$past(reset) |-> config_done == $past(startup_request); endproperty
   a_cfg: assert property (p_cfg) else $error("done not following request");
   property p_cfg_lock; HOLD_UNTIL_LOCK && locked && startup_request |=> config_done; endproperty
   a_cfg_lock: assert property (p_cfg_lock) else $error("done missing after lock");
   property p_keep; locked |=> locked; endproperty
   a_keep: assert property (p_keep) else $error("lock lost");
   property p_drift; drift_exceeded |=> drift_exceeded && locked; endproperty
   a_drift: assert property (p_drift) else $error("drift flag or lock dropped");
   property p_dbl_pre; !locked && clocks.doubled_clock_out |-> clocks.zero_phase_clock_out; endproperty
   a_dbl_pre: assert property (p_dbl_pre) else $error("doubled high outside first half");
   property p_dbl_post; s_zrise |-> clocks.doubled_clock_out; endproperty
   a_dbl_post: assert property (p_dbl_post) else $error("doubled not aligned");
   property p_reach; !$past(reset) |-> network_reach == (LOOP_INDEX[2] ? 4'hC : 4'h3); endproperty
   a_reach: assert property (p_reach) else $error("wrong network mask");
endmodule : dllcm_asserts

// >>> bench/dllcm_manager_tb.sv
// Self-checking bench for the clock manager model
`timescale 1ns/100ps
module dllcm_manager_tb;
   import dllcm_pkg::*;
   localparam logic [5:0] RQ [8] = '{DIV_1P5, DIV_2, DIV_2P5, DIV_3, DIV_4, DIV_5, DIV_8, DIV_16};
   localparam logic [15:0] RP [8] = '{16'h0018, 16'h0020, 16'h0028, 16'h0030, 16'h0040, 16'h0050, 16'h0080, 16'h0100};
   logic             clk, reset, req, run, src, cfg, drift;
   logic [7:0]       per;
   logic [3:0]       reach;
   logic [8:0]       lkv;
   dllcm_clocks_type ck [9];
   int               n_mismatch, num_checks, n;
   // One loop per ratio, all on one source
   for (genvar i = 0; i < 8; i++) begin : g_div
      dllcm_manager #(.DIVIDE_RATIO(RQ[i]), .LOCK_COUNT(4)) u_div (.clk(clk), .reset(reset), .source_clock_in(src),
         .startup_request(req), .config_done(), .clocks(ck[i]), .locked(lkv[i]), .drift_exceeded(),
         .network_reach());
   end
   dllcm_manager #(.HOLD_UNTIL_LOCK(1'b1), .LOCK_COUNT(4), .LOOP_INDEX(3'h4)) u_dut (.clk(clk), .reset(reset),
      .source_clock_in(src), .startup_request(req), .config_done(cfg), .clocks(ck[8]), .locked(lkv[8]),
      .drift_exceeded(drift), .network_reach(reach));
   dllcm_source u_src (.clk(clk), .period(per), .run(run), .src(src));
   // 40 MHz clock
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // Compare and count
   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", name, exp, got);
      end
   endtask : chk
   task automatic stop_test;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : stop_test
   task automatic tick(inout int t);
      @(negedge clk);
      if (++t > 3000) begin
         n_mismatch++;
         $display("BAD wait expected event seen timeout");
         stop_test();
      end
   endtask : tick
   function automatic logic pick(input int i, input int f);
      return f == 0 ? ck[i].zero_phase_clock_out : f == 1 ? ck[i].doubled_clock_out : ck[i].divided_clock_out;
   endfunction : pick
   // Clocks between two rises of one output
   task automatic period_of(input int i, input int f, output int p);
      int r, t;
      logic prev;
      r = 0;
      t = 0;
      p = 0;
      prev = 1'b1;
      while (r < 2) begin
         tick(t);
         if (r == 1) p++;
         if (pick(i, f) && !prev) r++;
         prev = pick(i, f);
      end
   endtask : period_of
   task automatic wait_lock;
      int t;
      t = 0;
      while (lkv[8] !== 1'b1) tick(t);
   endtask : wait_lock
   // Main sequence
   initial begin
      int t;
      logic prev;
      reset = 1'b1;
      req = 1'b1;
      run = 1'b1;
      per = 8'h10;
      n_mismatch = 0;
      num_checks = 0;
      repeat (2) @(negedge clk);
      reset = 1'b0;
      chk("done_early", 16'h0000, {15'h0, cfg});
      wait_lock;
      @(negedge clk);
      chk("done_late", 16'h0001, {15'h0, cfg});
      chk("all_locked", 16'h01FF, {7'h0, lkv});
      chk("reach", 16'h000C, {12'h0, reach});
      for (int i = 0; i < 8; i++) begin
         period_of(i, 2, n);
         chk("divided_period", RP[i], 16'(n));
      end
      period_of(8, 2, n);
      chk("default_divided", 16'h0020, 16'(n));
      period_of(8, 1, n);
      chk("doubled_period", 16'h0008, 16'(n));
      $display("ratio test done");
      run = 1'b0;
      n = 0;
      prev = ck[8].zero_phase_clock_out;
      repeat (300) begin
         @(negedge clk);
         if (ck[8].zero_phase_clock_out && !prev) n++;
         prev = ck[8].zero_phase_clock_out;
      end
      chk("flush_cycles", 16'h0001, {15'h0, n >= 1 && n <= 4});
      chk("lock_stopped", 16'h0001, {15'h0, lkv[8]});
      run = 1'b1;
      n = 0;
      t = 0;
      prev = src;
      while (!ck[8].zero_phase_clock_out) begin
         tick(t);
         if (src && !prev) n++;
         prev = src;
      end
      chk("fill_cycles", 16'h0001, {15'h0, n >= 1 && n <= 4});
      chk("lock_resumed", 16'h0001, {15'h0, lkv[8]});
      $display("stop test done");
      per = 8'h14;
      repeat (200) @(negedge clk);
      chk("drift_flag", 16'h0001, {15'h0, drift});
      chk("lock_drift", 16'h0001, {15'h0, lkv[8]});
      reset = 1'b1;
      @(negedge clk);
      chk("lock_reset", 16'h0000, {15'h0, lkv[8]});
      reset = 1'b0;
      @(negedge clk);
      chk("drift_cleared", 16'h0000, {15'h0, drift});
      wait_lock;
      period_of(8, 0, n);
      chk("zero_period", 16'h0014, 16'(n));
      $display("drift test done");
      stop_test();
   end
endmodule : dllcm_manager_tb

bind dllcm_manager dllcm_asserts #(.HOLD_UNTIL_LOCK(HOLD_UNTIL_LOCK), .LOOP_INDEX(LOOP_INDEX)) u_chk (.clk(clk),
   .reset(reset), .startup_request(startup_request), .config_done(config_done), .clocks(clocks),
   .locked(locked), .drift_exceeded(drift_exceeded), .network_reach(network_reach));

// >>> bench/dllcm_source.sv
// Source clock model that stops only in its low phase
`timescale 1ns/100ps
module dllcm_source (
   // Clock and control
   input  wire logic       clk,
   input  wire logic [7:0] period,
   input  wire logic       run,
   // Source clock
   output logic            src
);
   logic [7:0] cnt;
   logic [7:0] per_q;
   logic       run_q;
   // Start low and idle
   initial begin
      cnt = 8'h00;
      src = 1'b0;
   end
   // Controls taken on the rising edge, away from the bench's falling-edge drive
   always @(posedge clk) begin
      run_q <= run;
      per_q <= period;
   end
   // Square wave; a stop ends the cycle, a restart opens high
   always @(negedge clk) begin
      if (cnt != 8'h00 || run_q) begin
         src <= cnt < (per_q >> 1);
         cnt <= (cnt == per_q - 8'h01) ? 8'h00 : cnt + 8'h01;
      end
   end
endmodule : dllcm_source

// >>> verilog/dllcm_divider.sv
// Divided clock generator counting quarter-period ticks
`timescale 1ns/100ps
module dllcm_divider (
   // Clock and reset
   input  wire logic                      clk,
   input  wire logic                      reset,
   // Control
   input  wire logic                      enable,
   input  wire logic                      tick,
   input  wire logic [dllcm_pkg::QW-1:0]  quarters,
   // Output
   output logic                           divided
);
   import dllcm_pkg::*;

   logic [QW-1:0] count;
   logic          wrap;

   // Half period ends after the chosen number of quarter ticks
   assign wrap = (count == quarters - QW'(1));

   // Tick counter and output toggle
   always_ff @(posedge clk) begin
      if (reset || !enable) begin
         count   <= '0;
         divided <= 1'b0;
      end else if (tick) begin
         count   <= wrap ? '0 : count + QW'(1);
         divided <= wrap ? ~divided : divided;   // [RULE1]
      end
   end

endmodule : dllcm_divider

// >>> verilog/dllcm_manager.sv
// Behavioural delay-locked loop clock manager built on the system clock
//
// Notes on behaviour
// [RULE1] The divided output runs at the zero-phase frequency over N, N being 1.5, 2, 2.5, 3, 4, 5, 8 or 16.
// [RULE2] With no ratio given the divided output runs at half the zero-phase frequency.
// [RULE3] With hold-until-lock set, configuration complete stays low until lock; by default it does not wait.
// [RULE4] Lock and valid outputs hold while the input period stays within 1 ns of the period at lock.
// [RULE5] The controller must pulse the loop reset after changing the input period beyond that drift.
// [RULE6] The source stops its clock only while low, for under 100 us, and restarts with a full high period.
// [RULE7] Lock stays asserted while the input is stopped and after it resumes.
// [RULE8] After a stop one to four output cycles still emerge; after a restart none appear for one to four.
// [RULE9] An input phase shift reaches the outputs one to four cycles later without disturbing lock.
// [RULE10] User logic must not use the output clocks before lock is asserted.
// [RULE11] A secondary loop's doubled output may feed this loop's source input directly.
// [RULE12] Each loop drives at most the two global buffers on its own edge.
// [RULE13] Two loops in one half-edge may cascade without a global buffer to give four times the input.
// [RULE14] Each of the eight loops reaches two of the four global networks, two per edge at once.
// [RULE15] Loop reset drops the lock indicator within four source clock cycles.
// [RULE16] Before lock the doubled output runs at the input rate with a 25/75 duty cycle.
// [RULE17] Lock is asserted after a configurable count of consecutive stable input cycles.
`timescale 1ns/100ps
module dllcm_manager #(
   parameter logic [dllcm_pkg::QW-1:0] DIVIDE_RATIO    = dllcm_pkg::DIV_2,
   parameter bit                       HOLD_UNTIL_LOCK = 1'b0,
   parameter int                       LOCK_COUNT      = dllcm_pkg::LOCK_COUNT_DEF,
   parameter logic [2:0]               LOOP_INDEX      = 3'h0
) (
   // Clock and reset
   input  wire logic                           clk,
   input  wire logic                           reset,
   // Source clock, sampled as a level
   input  wire logic                           source_clock_in,
   // Startup sequencer
   input  wire logic                           startup_request,
   output logic                                config_done,
   // Generated clocks and status
   output dllcm_pkg::dllcm_clocks_type         clocks,
   output logic                                locked,
   output logic                                drift_exceeded,
   output logic [dllcm_pkg::NETWORKS-1:0]      network_reach
);
   import dllcm_pkg::*;

   // ----------------------------------------------------------------
   // Input sampling and edge detect
   // ----------------------------------------------------------------
   logic src_meta;
   logic src_sync;
   logic src_prev;
   logic rise;

   // Two-stage synchroniser, then edge history
   always_ff @(posedge clk) begin
      src_meta <= source_clock_in;   // [RULE11]
      src_sync <= src_meta;
      src_prev <= src_sync;
   end

   assign rise = src_sync & ~src_prev;

   // ----------------------------------------------------------------
   // Period measurement and stop detection
   // ----------------------------------------------------------------
   logic [IW-1:0] since_rise;
   logic [IW-1:0] last_interval;
   logic          have_edge;
   logic          stopped;
   logic          valid_rise;
   logic          stop_seen;

   // A rise counts only after a previous rise with no stop between; an over-long gap is a restart
   assign valid_rise = rise & have_edge & ~stopped & ~stop_seen;   // [RULE6]
   assign stop_seen  = have_edge & ~stopped & ({1'b0, since_rise} > {last_interval, 1'b0});

   // Interval counter between input rises
   always_ff @(posedge clk) begin
      if (reset) begin
         since_rise    <= IVAL_ONE;
         last_interval <= IVAL_MAX;
         have_edge     <= 1'b0;
         stopped       <= 1'b0;
      end else if (rise) begin
         since_rise    <= IVAL_ONE;
         last_interval <= valid_rise ? since_rise : last_interval;
         have_edge     <= 1'b1;
         stopped       <= 1'b0;   // [RULE6] restart resumes measurement
      end else begin
         since_rise    <= (since_rise == IVAL_MAX) ? since_rise : since_rise + IVAL_ONE;
         stopped       <= stopped | stop_seen;
      end
   end

   // ----------------------------------------------------------------
   // Lock acquisition and drift watch
   // ----------------------------------------------------------------
   logic [IW-1:0] lock_period;
   logic [IW-1:0] stable_count;
   logic [IW-1:0] step_diff;
   logic [IW-1:0] lock_diff;
   logic          step_ok;
   logic          lock_reached;

   assign step_diff    = (since_rise >= last_interval) ? since_rise - last_interval : last_interval - since_rise;
   assign lock_diff    = (since_rise >= lock_period) ? since_rise - lock_period : lock_period - since_rise;
   assign step_ok      = (step_diff <= DRIFT_CYCLES);
   assign lock_reached = (stable_count >= IW'(LOCK_COUNT - 1));

   // Lock counter; stops and phase shifts leave lock alone
   always_ff @(posedge clk) begin
      if (reset) begin
         stable_count   <= '0;
         lock_period    <= '0;
         locked         <= 1'b0;   // [RULE15]
         drift_exceeded <= 1'b0;
      end else if (valid_rise && !locked) begin
         stable_count   <= step_ok ? stable_count + IVAL_ONE : '0;
         lock_period    <= since_rise;
         locked         <= step_ok & lock_reached;   // [RULE17]
      end else if (valid_rise) begin
         drift_exceeded <= drift_exceeded | (lock_diff > DRIFT_CYCLES);   // [RULE4] [RULE5]
      end
   end

   // ----------------------------------------------------------------
   // Delay line of measured input cycles
   // ----------------------------------------------------------------
   logic [IW-1:0] line [LINE_DEPTH];
   logic [1:0]    wr_ptr;
   logic [1:0]    rd_ptr;
   logic [2:0]    fill;
   logic          push;
   logic          pop;
   logic          running;
   logic [IW-1:0] cur_interval;
   logic [IW-1:0] phase;
   logic          period_end;
   logic          start;

   assign push       = valid_rise & (fill != LINE_DEPTH);
   assign period_end = running & (phase >= cur_interval - IVAL_ONE);
   assign start      = ~running & (fill >= LINE_FILL);   // [RULE8] refill wait
   assign pop        = start | (period_end & (fill != 3'h0));

   // Cycle store, replayed in order so shifts emerge later
   always_ff @(posedge clk) begin
      if (push) begin
         line[wr_ptr] <= since_rise;   // [RULE9]
      end
   end

   // Pointers, fill level and replay state
   always_ff @(posedge clk) begin
      if (reset) begin
         wr_ptr       <= '0;
         rd_ptr       <= '0;
         fill         <= '0;
         running      <= 1'b0;
         phase        <= '0;
         cur_interval <= IVAL_MAX;
      end else begin
         wr_ptr       <= push ? wr_ptr + 2'h1 : wr_ptr;
         rd_ptr       <= pop ? rd_ptr + 2'h1 : rd_ptr;
         fill         <= fill + {2'h0, push} - {2'h0, pop};
         cur_interval <= pop ? line[rd_ptr] : cur_interval;
         running      <= start | (running & ~(period_end & ~pop));   // [RULE8] flush then stop
         phase        <= (start | period_end) ? '0 : phase + IVAL_ONE;
      end
   end

   // ----------------------------------------------------------------
   // Waveform shaping
   // ----------------------------------------------------------------
   logic [IW-1:0] quarter_pt;
   logic [IW-1:0] half_pt;
   logic [IW-1:0] three_q_pt;
   logic          next_zero;
   logic          next_doubled;
   logic          quarter_tick;
   logic          zero_out;
   logic          doubled_out;
   logic          divided_out;

   assign quarter_pt   = cur_interval >> 2;
   assign half_pt      = cur_interval >> 1;
   assign three_q_pt   = quarter_pt + half_pt;
   assign next_zero    = running & (phase < half_pt);
   assign next_doubled = running & ((phase < quarter_pt)   // [RULE16] 25/75 before lock
                       | (locked & (phase >= half_pt) & (phase < three_q_pt)));   // [RULE13]
   assign quarter_tick = running & ((phase == '0) | (phase == quarter_pt)
                       | (phase == half_pt) | (phase == three_q_pt));

   // Zero-phase and doubled outputs
   always_ff @(posedge clk) begin
      if (reset) begin
         zero_out    <= 1'b0;
         doubled_out <= 1'b0;
      end else begin
         zero_out    <= next_zero;   // [RULE7] [RULE10]
         doubled_out <= next_doubled;
      end
   end

   // Divided output counts quarter periods of the replayed cycle
   dllcm_divider u_divider (
      .clk      (clk),
      .reset    (reset),
      .enable   (running),
      .tick     (quarter_tick),
      .quarters (DIVIDE_RATIO),   // [RULE1] [RULE2]
      .divided  (divided_out)
   );

   // One driver for the whole clock bundle, each member a flop
   assign clocks = '{zero_phase_clock_out: zero_out,
                     doubled_clock_out:    doubled_out,
                     divided_clock_out:    divided_out};

   // ----------------------------------------------------------------
   // Startup and global network reach
   // ----------------------------------------------------------------
   logic                next_config_done;
   logic [NETWORKS-1:0] next_reach;

   assign next_config_done = startup_request & (~HOLD_UNTIL_LOCK | locked);
   // Top loops reach networks 0 and 1, bottom loops 2 and 3
   assign next_reach       = LOOP_INDEX[2] ? 4'hC : 4'h3;

   // Registered startup handshake and reach mask
   always_ff @(posedge clk) begin
      if (reset) begin
         config_done   <= 1'b0;
         network_reach <= '0;
      end else begin
         config_done   <= next_config_done;   // [RULE3]
         network_reach <= next_reach;         // [RULE12] [RULE14]
      end
   end

endmodule : dllcm_manager

// >>> verilog/dllcm_pkg.sv
// Constants and types shared by the delay-locked loop clock manager model
package dllcm_pkg;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_PS   = 25000;            // 40 MHz system clock
   localparam int DRIFT_PS        = 1000;             // Tolerated input period drift, 1 ns
   localparam int DRIFT_RAW       = DRIFT_PS / CLK_PERIOD_PS;
   localparam int DRIFT_CYCLES_I  = (DRIFT_RAW < 1) ? 1 : DRIFT_RAW;
   localparam int LOCK_COUNT_DEF  = 16;               // Stable input cycles before lock

   // ----------------------------------------------------------------
   // Widths and delay line
   // ----------------------------------------------------------------
   localparam int IW              = 16;               // Interval counter width
   localparam int QW              = 6;                // Quarter tick counter width
   localparam logic [IW-1:0] DRIFT_CYCLES = IW'(DRIFT_CYCLES_I);
   localparam logic [IW-1:0] IVAL_MAX     = 16'hFFFF;
   localparam logic [IW-1:0] IVAL_ONE     = 16'h0001;
   localparam logic [2:0]    LINE_DEPTH   = 3'h4;     // Delay line holds up to four cycles
   localparam logic [2:0]    LINE_FILL    = 3'h2;     // Cycles buffered before output starts

   // ----------------------------------------------------------------
   // Divide ratio, as quarter input periods per divided half period
   // ----------------------------------------------------------------
   localparam logic [QW-1:0] DIV_1P5 = 6'h03;
   localparam logic [QW-1:0] DIV_2   = 6'h04;
   localparam logic [QW-1:0] DIV_2P5 = 6'h05;
   localparam logic [QW-1:0] DIV_3   = 6'h06;
   localparam logic [QW-1:0] DIV_4   = 6'h08;
   localparam logic [QW-1:0] DIV_5   = 6'h0A;
   localparam logic [QW-1:0] DIV_8   = 6'h10;
   localparam logic [QW-1:0] DIV_16  = 6'h20;

   // ----------------------------------------------------------------
   // Global network reach
   // ----------------------------------------------------------------
   localparam int NETWORKS = 4;

   // Clock outputs travel together
   typedef struct packed {
      logic zero_phase_clock_out;
      logic doubled_clock_out;
      logic divided_clock_out;
   } dllcm_clocks_type;

endpackage : dllcm_pkg
